/* File: wcd_pkg.sv */
package wcd_pkg;
    localparam int KEY_W = 15;
    localparam int SET_W = 10;
    localparam int ADDR_W = KEY_W + SET_W;
    localparam int SETS = 1 << SET_W;
    localparam int ST_W = 2;
    localparam logic [1:0] ST_INVALID = 2'h0;
    localparam logic [1:0] ST_COPY = 2'h1;
    localparam logic [1:0] ST_PRIVATE = 2'h2;
    localparam logic [1:0] ST_MODIFIED = 2'h3;
    localparam logic [1:0] SPY_IO_PUB_RD = 2'h0;
    localparam logic [1:0] SPY_CM_PUB_RD = 2'h1;
    localparam logic [1:0] SPY_IO_WR = 2'h2;
    localparam logic [1:0] SPY_PRIV_RD = 2'h3;
    localparam logic [1:0] MEM_WRITE = 2'h1;
    localparam logic [1:0] MEM_NORMAL_RD = 2'h2;
    localparam logic [1:0] MEM_PRIVATE_RD = 2'h3;
    localparam int DIR_W = KEY_W + ST_W;

    typedef enum logic [3:0] {
        MS_IDLE = 4'h1,
        MS_WBACK = 4'h2,
        MS_FETCH = 4'h4,
        MS_FILL = 4'h8
    } wcd_miss_t;

    function automatic logic [KEY_W-1:0] key_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:SET_W];
    endfunction

    function automatic logic [SET_W-1:0] set_of(input logic [ADDR_W-1:0] a);
        return a[SET_W-1:0];
    endfunction
endpackage

/* File: wcd_dir_ram.sv */
`timescale 1ns/1ps
module wcd_dir_ram
    import wcd_pkg::*;
(
    input wire logic clk_i,
    input wire logic [SET_W-1:0] rd_addr_i,
    output logic [DIR_W-1:0] rd_data_o,
    input wire logic [SET_W-1:0] rd2_addr_i,
    output logic [DIR_W-1:0] rd2_data_o,
    input wire logic wr_en_i,
    input wire logic [SET_W-1:0] wr_addr_i,
    input wire logic [DIR_W-1:0] wr_data_i
);
    // Key and state per set; state lives in low bits; no reset, cleared by sweep
    logic [DIR_W-1:0] mem [SETS];

    always_ff @(posedge clk_i)
    begin
        if (wr_en_i)
        begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
        rd2_data_o <= mem[rd2_addr_i];
    end
endmodule

/* File: wcd_directory.sv */
`timescale 1ns/1ps
module wcd_directory
    import wcd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [ADDR_W-1:0] req_base_i,
    output logic req_hold_o,
    output logic ret_valid_o,
    output logic ret_write_o,
    output logic [ADDR_W-1:0] ret_addr_o,
    output logic mem_req_o,
    output logic [1:0] mem_cmd_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    input wire logic mem_ack_i,
    input wire logic fill_valid_i,
    input wire logic fill_modified_i,
    input wire logic fill_copy_i,
    input wire logic snoop_valid_i,
    input wire logic [1:0] snoop_cmd_i,
    input wire logic snoop_io_rmw_i,
    input wire logic [ADDR_W-1:0] snoop_addr_i,
    output logic snoop_supply_o,
    output logic snoop_modified_o,
    output logic snoop_copy_o,
    output logic snoop_inhibit_o,
    output logic [ADDR_W-1:0] snoop_supply_addr_o
);
    typedef struct packed {
        logic init;
        logic [SET_W-1:0] init_cnt;
        logic t1_v;
        logic t1_w;
        logic [ADDR_W-1:0] t1_a;
        logic t2_v;
        logic t2_w;
        logic [ADDR_W-1:0] t2_a;
        logic t3_v;
        logic t3_w;
        logic [ADDR_W-1:0] t3_a;
        logic [KEY_W-1:0] vict_key;
        wcd_miss_t ms;
        logic mem_req;
        logic [1:0] mem_cmd;
        logic [ADDR_W-1:0] mem_addr;
        logic ret_v;
        logic ret_w;
        logic [ADDR_W-1:0] ret_a;
        logic sp_v;
        logic [1:0] sp_cmd;
        logic sp_rmw;
        logic [ADDR_W-1:0] sp_a;
        logic sup;
        logic sup_mod;
        logic sup_copy;
        logic [ADDR_W-1:0] sup_a;
    } wcd_state_t;

    wcd_state_t s_reg;
    wcd_state_t s_next;
    logic [DIR_W-1:0] dir_rd;
    logic [DIR_W-1:0] sp_rd;
    logic [SET_W-1:0] rd_addr;
    logic wr_en;
    logic [SET_W-1:0] wr_addr;
    logic [DIR_W-1:0] wr_data;
    logic t1_hit;
    logic [1:0] t1_st;
    logic sp_hit;
    logic [1:0] sp_st;
    logic sp_wr;
    logic [DIR_W-1:0] sp_wdata;
    logic t1_wr;
    logic [DIR_W-1:0] t1_wdata;

    // Lookup stage reads at the address it is about to hold, so data aligns
    wcd_dir_ram u_ram (
        .clk_i(clk_i),
        .rd_addr_i(rd_addr),
        .rd_data_o(dir_rd),
        .rd2_addr_i(set_of(snoop_addr_i)),
        .rd2_data_o(sp_rd),
        .wr_en_i(wr_en),
        .wr_addr_i(wr_addr),
        .wr_data_i(wr_data)
    );

    assign t1_st = dir_rd[ST_W-1:0];
    assign t1_hit = s_reg.t1_v && t1_st != ST_INVALID && dir_rd[DIR_W-1:ST_W] == key_of(s_reg.t1_a);
    assign sp_st = sp_rd[ST_W-1:0];
    assign sp_hit = s_reg.sp_v && sp_st != ST_INVALID && sp_rd[DIR_W-1:ST_W] == key_of(s_reg.sp_a);
    assign req_hold_o = s_reg.init || (s_reg.t1_v && !(t1_hit || !s_reg.t3_v));
    assign ret_valid_o = s_reg.ret_v;
    assign ret_write_o = s_reg.ret_w;
    assign ret_addr_o = s_reg.ret_a;
    assign mem_req_o = s_reg.mem_req;
    assign mem_cmd_o = s_reg.mem_cmd;
    assign mem_addr_o = s_reg.mem_addr;
    assign snoop_supply_o = s_reg.sup;
    assign snoop_modified_o = s_reg.sup_mod;
    assign snoop_copy_o = s_reg.sup_copy;
    assign snoop_inhibit_o = s_reg.sup;
    assign snoop_supply_addr_o = s_reg.sup_a;

    // Snoop response; a hit may need a state change or data supply
    always_comb
    begin
        sp_wr = 1'b0;
        sp_wdata = sp_rd;
        if (sp_hit)
        begin
            case (s_reg.sp_cmd)
                SPY_PRIV_RD:
                begin
                    sp_wr = 1'b1;
                    sp_wdata = {sp_rd[DIR_W-1:ST_W], ST_INVALID};
                end
                SPY_IO_WR:
                begin
                    sp_wr = 1'b1;
                    sp_wdata = {sp_rd[DIR_W-1:ST_W], ST_INVALID};
                end
                SPY_IO_PUB_RD:
                begin
                    sp_wr = s_reg.sp_rmw;
                    sp_wdata = {sp_rd[DIR_W-1:ST_W], ST_INVALID};
                end
                SPY_CM_PUB_RD:
                begin
                    // holder of private drops to copy, modified leaves
                    sp_wr = sp_st != ST_COPY;
                    sp_wdata = {sp_rd[DIR_W-1:ST_W], (sp_st == ST_PRIVATE) ? ST_COPY : ST_INVALID};
                end
                default:
                begin
                    sp_wr = 1'b0;
                end
            endcase
        end
    end

    // Write hit on private or modified rewrites cache, no memory access
    assign t1_wr = t1_hit && s_reg.t1_w && t1_st != ST_COPY;
    assign t1_wdata = {key_of(s_reg.t1_a), ST_MODIFIED};

    always_comb
    begin
        s_next = s_reg;
        wr_en = 1'b0;
        wr_addr = set_of(s_reg.t1_a);
        wr_data = t1_wdata;
        s_next.ret_v = 1'b0;
        s_next.sup = 1'b0;
        s_next.sp_v = snoop_valid_i;
        s_next.sp_cmd = snoop_valid_i ? snoop_cmd_i : SPY_IO_PUB_RD;
        s_next.sp_rmw = snoop_io_rmw_i;
        s_next.sp_a = snoop_addr_i;
        rd_addr = set_of(s_reg.t1_a);

        if (s_reg.init)
        begin
            // Sweep every set to not-valid after reset
            wr_en = 1'b1;
            wr_addr = s_reg.init_cnt;
            wr_data = {{KEY_W{1'b0}}, ST_INVALID};
            s_next.init_cnt = s_reg.init_cnt + 1'b1;
            s_next.init = s_reg.init_cnt != SET_W'(SETS - 1);
        end
        else if (s_reg.ms == MS_FILL && fill_valid_i)
        begin
            // Fill has priority over the snoop and local writers; only the reset sweep comes before it
            wr_en = 1'b1;
            wr_addr = set_of(s_reg.t3_a);
            if (s_reg.t3_w || fill_modified_i)
            begin
                wr_data = {key_of(s_reg.t3_a), ST_MODIFIED};
            end
            else if (fill_copy_i)
            begin
                wr_data = {key_of(s_reg.t3_a), ST_COPY};
            end
            else
            begin
                wr_data = {key_of(s_reg.t3_a), ST_PRIVATE};
            end
        end
        else if (sp_wr)
        begin
            // Snoop beats local rewrite; the local rewrite is dropped and the lookup still completes
            wr_en = 1'b1;
            wr_addr = set_of(s_reg.sp_a);
            wr_data = sp_wdata;
        end
        else if (t1_wr)
        begin
            wr_en = 1'b1;
        end

        // Modified data must be supplied, except for a module write
        if (sp_hit && sp_st == ST_MODIFIED && s_reg.sp_cmd != SPY_IO_WR)
        begin
            s_next.sup = 1'b1;
            s_next.sup_mod = 1'b1;
            s_next.sup_copy = 1'b0;
            s_next.sup_a = s_reg.sp_a;
        end
        else if (sp_hit && s_reg.sp_cmd == SPY_CM_PUB_RD)
        begin
            s_next.sup_copy = 1'b1;
            s_next.sup_mod = 1'b0;
        end
        else
        begin
            s_next.sup_copy = 1'b0;
            s_next.sup_mod = 1'b0;
        end
        // module write hit falls through with no action

        // Miss sequencer
        case (s_reg.ms)
            MS_IDLE:
            begin
                s_next.mem_req = 1'b0;
            end
            MS_WBACK:
            begin
                if (mem_ack_i)
                begin
                    s_next.ms = MS_FETCH;
                    s_next.mem_cmd = s_reg.t3_w ? MEM_PRIVATE_RD : MEM_NORMAL_RD;
                    s_next.mem_addr = s_reg.t3_a;
                end
            end
            MS_FETCH:
            begin
                if (mem_ack_i)
                begin
                    s_next.ms = MS_FILL;
                    s_next.mem_req = 1'b0;
                end
            end
            MS_FILL:
            begin
                if (fill_valid_i)
                begin
                    s_next.ms = MS_IDLE;
                    s_next.t3_v = 1'b0;
                    s_next.ret_v = 1'b1;
                    s_next.ret_w = s_reg.t3_w;
                    s_next.ret_a = s_reg.t3_a;
                end
            end
            default:
            begin
                s_next.ms = MS_IDLE;
            end
        endcase

        // Pipeline; a snoop write on the same set retries a hitting lookup that has no local rewrite
        if (!s_reg.init && s_reg.t1_v && !(sp_wr && !t1_wr && wr_addr == set_of(s_reg.t1_a) && t1_hit))
        begin
            if (t1_hit)
            begin
                s_next.t2_v = 1'b1;
                s_next.t2_w = s_reg.t1_w;
                s_next.t2_a = s_reg.t1_a;
                s_next.t1_v = 1'b0;
                s_next.ret_v = 1'b1;
                s_next.ret_w = s_reg.t1_w && t1_st != ST_COPY;
                s_next.ret_a = s_reg.t1_a;
                if (s_reg.t1_w && t1_st == ST_COPY)
                begin
                    // Copy hit on write upgrades like a miss
                    s_next.ret_v = 1'b0;
                    s_next.t2_v = 1'b0;
                    s_next.t1_v = 1'b1;
                end
            end
            if ((!t1_hit || (s_reg.t1_w && t1_st == ST_COPY)) && !s_reg.t3_v)
            begin
                s_next.t3_v = 1'b1;
                s_next.t3_w = s_reg.t1_w;
                s_next.t3_a = s_reg.t1_a;
                s_next.t1_v = 1'b0;
                s_next.mem_req = 1'b1;
                if (t1_st == ST_MODIFIED && !t1_hit)
                begin
                    s_next.ms = MS_WBACK;
                    s_next.mem_cmd = MEM_WRITE;
                    s_next.mem_addr = {dir_rd[DIR_W-1:ST_W], set_of(s_reg.t1_a)};
                end
                else
                begin
                    s_next.ms = MS_FETCH;
                    s_next.mem_cmd = s_reg.t1_w ? MEM_PRIVATE_RD : MEM_NORMAL_RD;
                    s_next.mem_addr = s_reg.t1_a;
                end
            end
        end
        else if (s_reg.t2_v && s_reg.ret_v == 1'b0)
        begin
            s_next.t2_v = 1'b0;
        end
        if (s_next.t1_v == 1'b0 && s_reg.t2_v && !t1_hit)
        begin
            s_next.t2_v = 1'b0;
        end

        // Queue head enters when lookup stage is free
        if (!req_hold_o && req_valid_i && (!s_reg.t1_v || t1_hit || !s_reg.t3_v))
        begin
            s_next.t1_v = 1'b1;
            s_next.t1_w = req_write_i;
            s_next.t1_a = ADDR_W'(req_addr_i + req_base_i);
        end
        rd_addr = set_of(s_next.t1_a);
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_reg <= '0;
            s_reg.init <= 1'b1;
            s_reg.ms <= MS_IDLE;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    property p_wb_first;
        @(posedge clk_i) disable iff (!rst_n_i)
        (s_reg.ms == MS_WBACK) |-> (mem_req_o && mem_cmd_o == MEM_WRITE);
    endproperty
    a_wb_first: assert property (p_wb_first) else $error("writeback cmd wrong");

    property p_inhibit;
        @(posedge clk_i) disable iff (!rst_n_i)
        snoop_supply_o |-> snoop_inhibit_o && snoop_modified_o;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("supply without inhibit");

    property p_fill_done;
        @(posedge clk_i) disable iff (!rst_n_i)
        (s_reg.ms == MS_FILL && fill_valid_i) |=> ret_valid_o && s_reg.ms == MS_IDLE;
    endproperty
    a_fill_done: assert property (p_fill_done) else $error("fill not returned");

    property p_hit_no_bus;
        @(posedge clk_i) disable iff (!rst_n_i)
        (t1_hit && !s_reg.t1_w && s_reg.ms == MS_IDLE) |=> !mem_req_o;
    endproperty
    a_hit_no_bus: assert property (p_hit_no_bus) else $error("read hit used bus");

    property p_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        (s_reg.t1_v && !t1_hit && s_reg.t3_v && !s_reg.init) |-> req_hold_o;
    endproperty
    a_hold: assert property (p_hold) else $error("third miss not stalled");

    property p_iowr;
        @(posedge clk_i) disable iff (!rst_n_i)
        (sp_hit && s_reg.sp_cmd == SPY_IO_WR && !s_reg.init && !(s_reg.ms == MS_FILL && fill_valid_i))
            |-> wr_en && wr_data[ST_W-1:0] == ST_INVALID;
    endproperty
    a_iowr: assert property (p_iowr) else $error("io write not invalidated");

    property p_iopub;
        @(posedge clk_i) disable iff (!rst_n_i)
        (sp_hit && s_reg.sp_cmd == SPY_IO_PUB_RD && !s_reg.sp_rmw) |-> !sp_wr;
    endproperty
    a_iopub: assert property (p_iopub) else $error("io public read changed state");

    property p_missfetch;
        @(posedge clk_i) disable iff (!rst_n_i)
        (s_reg.ms == MS_FETCH) |-> mem_req_o && mem_cmd_o == (s_reg.t3_w ? MEM_PRIVATE_RD : MEM_NORMAL_RD);
    endproperty
    a_missfetch: assert property (p_missfetch) else $error("fetch cmd wrong");
endmodule

/* File: wcd_mem_model.sv */
`timescale 1ns/1ps
module wcd_mem_model
    import wcd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    input wire logic mod_i,
    input wire logic copy_i,
    input wire logic mem_req_i,
    input wire logic [1:0] mem_cmd_i,
    output logic mem_ack_o,
    output logic fill_valid_o,
    output logic fill_modified_o,
    output logic fill_copy_o
);
    logic [7:0] wait_reg;
    logic [7:0] fill_reg;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wait_reg <= 8'h00;
            fill_reg <= 8'h00;
            mem_ack_o <= 1'b0;
            fill_valid_o <= 1'b0;
            fill_modified_o <= 1'b0;
            fill_copy_o <= 1'b1;
        end
        else
        begin
            mem_ack_o <= 1'b0;
            fill_valid_o <= 1'b0;
            // Status lines toggle outside a fill, so nothing may rely on them
            fill_modified_o <= ~fill_modified_o;
            fill_copy_o <= ~fill_copy_o;
            if (fill_reg != 8'h00)
            begin
                fill_reg <= fill_reg - 8'h01;
                if (fill_reg == 8'h01)
                begin
                    fill_valid_o <= 1'b1;
                    fill_modified_o <= mod_i;
                    fill_copy_o <= copy_i;
                end
            end
            if (mem_req_i && !mem_ack_o)
            begin
                if (wait_reg >= (slow_i ? 8'h14 : 8'h01))
                begin
                    mem_ack_o <= 1'b1;
                    wait_reg <= 8'h00;
                    // A writeback gets no data back
                    if (mem_cmd_i != MEM_WRITE)
                        fill_reg <= slow_i ? 8'h1e : 8'h02;
                end
                else
                    wait_reg <= wait_reg + 8'h01;
            end
        end
    end
endmodule

/* File: tb_writeback_cache_coherence_directory.sv */
`timescale 1ns/1ps
module tb_writeback_cache_coherence_directory
    import wcd_pkg::*;
;
    logic clk_i, rst_n_i, req_valid_i, req_write_i, req_hold_o, ret_valid_o, ret_write_o;
    logic [ADDR_W-1:0] req_addr_i, req_base_i, ret_addr_o, mem_addr_o, snoop_addr_i, snoop_supply_addr_o;
    logic mem_req_o, mem_ack_i, fill_valid_i, fill_modified_i, fill_copy_i, snoop_valid_i, snoop_io_rmw_i;
    logic [1:0] mem_cmd_o, snoop_cmd_i;
    logic snoop_supply_o, snoop_modified_o, snoop_copy_o, snoop_inhibit_o;
    logic slow, fmod, fcopy, hold_s, hold_seen, mreq_q, mack_q;
    logic [ADDR_W-1:0] a, b;
    logic [ADDR_W+3:0] exp_q[$];
    int miscompares = 0;
    int n_checks = 0;
    int i;

    wcd_directory uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
        .req_addr_i(req_addr_i), .req_base_i(req_base_i), .req_hold_o(req_hold_o), .ret_valid_o(ret_valid_o),
        .ret_write_o(ret_write_o), .ret_addr_o(ret_addr_o), .mem_req_o(mem_req_o), .mem_cmd_o(mem_cmd_o),
        .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .fill_valid_i(fill_valid_i),
        .fill_modified_i(fill_modified_i), .fill_copy_i(fill_copy_i), .snoop_valid_i(snoop_valid_i),
        .snoop_cmd_i(snoop_cmd_i), .snoop_io_rmw_i(snoop_io_rmw_i), .snoop_addr_i(snoop_addr_i),
        .snoop_supply_o(snoop_supply_o), .snoop_modified_o(snoop_modified_o), .snoop_copy_o(snoop_copy_o),
        .snoop_inhibit_o(snoop_inhibit_o), .snoop_supply_addr_o(snoop_supply_addr_o));

    wcd_mem_model mem (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow), .mod_i(fmod), .copy_i(fcopy),
        .mem_req_i(mem_req_o), .mem_cmd_i(mem_cmd_o), .mem_ack_o(mem_ack_i), .fill_valid_o(fill_valid_i),
        .fill_modified_o(fill_modified_i), .fill_copy_o(fill_copy_i));

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic bail();
        miscompares++;
        $display("wrong value at %0t: wait ran out", $time);
        end_of_test();
    endtask

    // Results may finish out of order, so a result matches any pending note
    task automatic got(input logic [ADDR_W+3:0] v);
        int k;
        n_checks++;
        for (k = 0; k < exp_q.size(); k++)
            if (exp_q[k] === v)
                break;
        if (k == exp_q.size())
        begin
            miscompares++;
            $display("wrong value at %0t: unexpected %h", $time, v);
        end
        else
            exp_q.delete(k);
    endtask

    always @(negedge clk_i)
    begin
        hold_s = req_hold_o;
        if (req_hold_o === 1'b1)
            hold_seen = 1'b1;
    end

    // Outputs launch on the rising edge, so look at them mid-cycle
    always @(negedge clk_i)
    begin
        if (rst_n_i === 1'b1)
        begin
            if (ret_valid_o === 1'b1)
                got({2'h1, 1'b0, ret_write_o, ret_addr_o});
            if (mem_req_o === 1'b1 && (mreq_q !== 1'b1 || mack_q === 1'b1))
                got({2'h2, mem_cmd_o, mem_addr_o});
            if (snoop_supply_o === 1'b1)
                got({2'h3, snoop_modified_o, snoop_inhibit_o, snoop_supply_addr_o});
            if (snoop_copy_o === 1'b1)
                got({2'h0, 2'h1, {ADDR_W{1'b0}}});
        end
        mreq_q <= mem_req_o;
        mack_q <= mem_ack_i;
    end

    task automatic req(input logic w, input logic [ADDR_W-1:0] ad);
        logic [ADDR_W-1:0] bs;
        int k;
        bs = ADDR_W'($urandom);
        req_valid_i <= 1'b1;
        req_write_i <= w;
        req_base_i <= bs;
        req_addr_i <= ad - bs;
        exp_q.push_back({2'h1, 1'b0, w, ad});
        for (k = 0; k < 3000; k++)
        begin
            @(posedge clk_i);
            if (hold_s === 1'b0)
                break;
        end
        if (k == 3000)
            bail();
    endtask

    task automatic settle();
        int k;
        req_valid_i <= 1'b0;
        req_addr_i <= ~req_addr_i;
        for (k = 0; k < 3000 && exp_q.size() != 0; k++)
            @(posedge clk_i);
        if (exp_q.size() != 0)
            bail();
        repeat (4) @(posedge clk_i);
    endtask

    function automatic void mem_is(input logic [1:0] c, input logic [ADDR_W-1:0] ad);
        exp_q.push_back({2'h2, c, ad});
    endfunction

    task automatic rd(input logic w, input logic [1:0] c, input logic m, input logic cp);
        if (c != 2'h0)
            mem_is(c, a);
        fmod <= m;
        fcopy <= cp;
        req(w, a);
        settle();
    endtask

    task automatic spy(input logic [1:0] c, input logic rmw, input logic [ADDR_W-1:0] ad, input logic sup);
        snoop_valid_i <= 1'b1;
        snoop_cmd_i <= c;
        snoop_io_rmw_i <= rmw;
        snoop_addr_i <= ad;
        if (sup)
            exp_q.push_back({2'h3, 2'h3, ad});
        @(posedge clk_i);
        snoop_valid_i <= 1'b0;
        snoop_cmd_i <= 2'h0;
        snoop_io_rmw_i <= 1'b0;
        snoop_addr_i <= ~ad;
        settle();
    endtask

    initial
    begin
        {rst_n_i, req_valid_i, req_write_i, snoop_valid_i, snoop_io_rmw_i, slow, fmod, fcopy} = 8'h00;
        {req_addr_i, req_base_i, snoop_addr_i, snoop_cmd_i} = '0;
        i = $urandom(32'h103e8c29);
        a = ADDR_W'($urandom);
        b = {~a[ADDR_W-1:SET_W], a[SET_W-1:0]};
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        settle();
        rd(1'b0, MEM_NORMAL_RD, 1'b0, 1'b0);
        rd(1'b0, 2'h0, 1'b0, 1'b0);
        rd(1'b1, 2'h0, 1'b0, 1'b0);
        spy(SPY_IO_PUB_RD, 1'b0, a, 1'b1);
        rd(1'b1, 2'h0, 1'b0, 1'b0);
        spy(SPY_PRIV_RD, 1'b0, a, 1'b1);
        rd(1'b0, MEM_NORMAL_RD, 1'b0, 1'b1);
        exp_q.push_back({2'h0, 2'h1, {ADDR_W{1'b0}}});
        spy(SPY_CM_PUB_RD, 1'b0, a, 1'b0);
        spy(SPY_IO_PUB_RD, 1'b0, a, 1'b0);
        rd(1'b0, 2'h0, 1'b0, 1'b0);
        rd(1'b1, MEM_PRIVATE_RD, 1'b0, 1'b0);
        rd(1'b1, 2'h0, 1'b0, 1'b0);
        spy(SPY_IO_WR, 1'b0, a, 1'b0);
        rd(1'b0, MEM_NORMAL_RD, 1'b1, 1'b0);
        rd(1'b1, 2'h0, 1'b0, 1'b0);
        spy(SPY_IO_PUB_RD, 1'b1, a, 1'b1);
        rd(1'b0, MEM_NORMAL_RD, 1'b0, 1'b0);
        spy(SPY_PRIV_RD, 1'b0, b, 1'b0);
        rd(1'b1, 2'h0, 1'b0, 1'b0);
        rd(1'b1, 2'h0, 1'b0, 1'b0);
        mem_is(MEM_WRITE, a);
        mem_is(MEM_NORMAL_RD, b);
        req(1'b0, b);
        settle();
        mem_is(MEM_NORMAL_RD, a);
        rd(1'b0, 2'h0, 1'b0, 1'b0);
        slow <= 1'b1;
        hold_seen = 1'b0;
        for (i = 1; i < 6; i++)
        begin
            b = {ADDR_W'($urandom)} >> SET_W << SET_W | ADDR_W'(a[SET_W-1:0] + SET_W'(i));
            if (i == 3)
                req(1'b0, a);
            else
            begin
                mem_is(MEM_NORMAL_RD, b);
                req(1'b0, b);
            end
        end
        settle();
        n_checks++;
        if (hold_seen !== 1'b1)
        begin
            miscompares++;
            $display("wrong value at %0t: queue never held", $time);
        end
        end_of_test();
    end

    initial
    begin
        repeat (60000) @(posedge clk_i);
        bail();
    end
endmodule
